// ==== inc/gps_pkg.sv ====
// Constants for the eight-pin port block with pin steering.
// Assumes a byte-wide register port and one 200 MHz clock.
package gps_pkg;
  localparam int unsigned ADDR_W  = 3;
  localparam int unsigned DATA_W  = 8;
  // Register offsets on the plain register port
  localparam logic [2:0] OFS_LEVEL = 3'h0;
  localparam logic [2:0] OFS_LATCH = 3'h1;
  localparam logic [2:0] OFS_DIR   = 3'h2;
  localparam logic [2:0] OFS_ANA   = 3'h3;
  localparam logic [2:0] OFS_STEER = 3'h4;
  // Reset values and implemented-bit masks
  localparam logic [7:0] DIR_RST   = 8'hff;
  localparam logic [7:0] LAT_RST   = 8'h00;
  localparam logic [7:0] ANA_MASK  = 8'h2f;
  localparam logic [7:0] ANA_RST   = 8'h2f;
  localparam logic [7:0] STR_MASK  = 8'h03;
  localparam logic [7:0] STR_RST   = 8'h00;
  // Steering field positions
  localparam int unsigned STR_CAPTURE_COMPARE_UNIT_TWO = 0;
  localparam int unsigned STR_SS   = 1;
  // Pins that the slave select may use
  localparam int unsigned SS_PIN_DEF = 5;
  localparam int unsigned SS_PIN_ALT = 0;
  // Synchroniser depth on pin inputs
  localparam int unsigned SYNC_LEN = 2;
endpackage

// ==== hw/gps_port.sv ====
// Port A logic: direction, output latch, pin level, analog select,
// and steering of slave select and capture unit two.
// Assumes the register master never asserts both strobes together.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////
// Function
// [R01] Eight pins, each usable as input or output.
// [R02] Direction bit 1 turns the pin driver off.
// [R03] Direction bit 0 drives the output latch bit on the pin.
// [R04] Level register reads pins; writes go to the latch.
// [R05] Level write stores the modified sampled value into latch.
// [R06] Latch write acts exactly like a level write.
// [R07] Latch read returns latch contents, not pins.
// [R08] Analog bit set disables the digital input buffer.
// [R09] Analog pins read zero on every digital read.
// [R10] Analog bits never gate digital outputs.
// [R11] Analog bits reset to the analog setting.
// [R12] Software keeps direction at input on analog pins.
// [R13] Enabled peripheral takes pin output from the latch; the capture two override value comes from its drive input instead.
// [R14] Steering bit 1 puts slave select on pin 5 or 0.
// [R15] Steering bit 0 puts capture two on C1 or B3.
// [R16] Steering leaves direction alone; overrides follow the function.
// [R17] Steering bits 7..2 read zero; bits 1..0 reset zero.
// [R18] Direction bits reset to one, all inputs.
// [R19] Analog bits 5 and 3..0 only; 7,6,4 read zero.
// [R20] Pin levels pass two flip-flops before the read path.
module gps_port
  import gps_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [7:0]        pad_in,
  output logic      [7:0]        pad_out,
  output logic      [7:0]        pad_oe,
  input  wire logic              ss_en,
  output logic                   ss_sense,
  input  wire logic              capture_compare_unit_two_drive,
  input  wire logic              capture_compare_unit_two_oen,
  output logic                   capture_compare_unit_two_sense,
  input  wire logic              pc1_in,
  input  wire logic              pb3_in,
  output logic                   pc1_ovr_en,
  output logic                   pc1_ovr_val,
  output logic                   pb3_ovr_en,
  output logic                   pb3_ovr_val
);

  ////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0] dir_q;
  logic [7:0] lat_q;
  logic [7:0] ana_q;
  logic [7:0] str_q;
  logic [7:0] rdat_q;
  logic [7:0] pout_q;
  logic [7:0] poe_q;
  logic       ss_q;
  logic       ccin_q;
  logic       c1en_q;
  logic       c1v_q;
  logic       b3en_q;
  logic       b3v_q;

  // Synchroniser stages; stage one feeds only stage two
  logic [7:0] pa_s1_q;
  logic [7:0] pa_s2_q;
  logic [1:0] oth_s1_q;
  logic [1:0] oth_s2_q;

  logic [7:0] dig_in;
  logic [7:0] rdat_d;
  logic [7:0] pout_d;
  logic [7:0] poe_d;
  logic       wr_lat;

  // Decode helper, shared by every write strobe qualifier
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Pads are asynchronous to mclk; two stages before any logic
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pa_s1_q  <= 8'h00;
      pa_s2_q  <= 8'h00;
      oth_s1_q <= 2'h0;
      oth_s2_q <= 2'h0;
    end
    else
    begin
      pa_s1_q  <= pad_in;              // see [R20]
      pa_s2_q  <= pa_s1_q;             // see [R20]
      oth_s1_q <= {pb3_in, pc1_in};
      oth_s2_q <= oth_s1_q;
    end
  end

  // Analog pins have no digital buffer, so they read as zero
  assign dig_in = pa_s2_q & ~(ana_q & ANA_MASK);   // see [R08] see [R09]

  ////////////////////////////////////////////////////////////////////
  // Direction register

  // Steering writes never touch this register
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      dir_q <= DIR_RST;                            // see [R18]
    else if (reg_wr && hit(reg_addr, OFS_DIR))
      dir_q <= reg_wdata;                          // see [R16]
  end

  ////////////////////////////////////////////////////////////////////
  // Output latch

  // Level and latch offsets share one write path; software does the
  // read and modify, the latch takes the merged byte
  assign wr_lat = reg_wr &&
                  (hit(reg_addr, OFS_LEVEL) || hit(reg_addr, OFS_LATCH));

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      lat_q <= LAT_RST;
    else if (wr_lat)
      lat_q <= reg_wdata;                 // see [R04] see [R05] see [R06]
  end

  ////////////////////////////////////////////////////////////////////
  // Analog select

  // Unimplemented bits are held at zero so reads need no extra mask
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      ana_q <= ANA_RST;                            // see [R11]
    else if (reg_wr && hit(reg_addr, OFS_ANA))
      ana_q <= reg_wdata & ANA_MASK;               // see [R19]
  end

  ////////////////////////////////////////////////////////////////////
  // Steering register

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      str_q <= STR_RST;                            // see [R17]
    else if (reg_wr && hit(reg_addr, OFS_STEER))
      str_q <= reg_wdata & STR_MASK;               // see [R17]
  end

  ////////////////////////////////////////////////////////////////////
  // Read path

  // Data stand only in the cycle after the read strobe
  always_comb
  begin
    rdat_d = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_LEVEL: rdat_d = dig_in;                // see [R04] see [R09]
        OFS_LATCH: rdat_d = lat_q;                 // see [R07]
        OFS_DIR:   rdat_d = dir_q;
        OFS_ANA:   rdat_d = ana_q;                 // see [R19]
        OFS_STEER: rdat_d = str_q;                 // see [R17]
        default:   rdat_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      rdat_q <= 8'h00;
    else
      rdat_q <= rdat_d;
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drivers

  // Latch drives when direction is 0; analog select plays no part.
  // Slave select is an input, so on its chosen pin the peripheral
  // holds the driver off; the other pin stays with the latch.
  always_comb
  begin
    pout_d = lat_q;                                // see [R03] see [R10]
    poe_d  = ~dir_q;                               // see [R01] see [R02]
    if (ss_en)
    begin
      if (str_q[STR_SS])
        poe_d[SS_PIN_ALT] = 1'b0;                  // see [R13] see [R14]
      else
        poe_d[SS_PIN_DEF] = 1'b0;                  // see [R13] see [R14]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pout_q <= LAT_RST;
      poe_q  <= 8'h00;
    end
    else
    begin
      pout_q <= pout_d;
      poe_q  <= poe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Peripheral steering

  // Override lines go to the port C and port B pin logic; only the
  // selected pin is overridden, the other one keeps its own latch
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ss_q   <= 1'b0;
      ccin_q <= 1'b0;
      c1en_q <= 1'b0;
      c1v_q  <= 1'b0;
      b3en_q <= 1'b0;
      b3v_q  <= 1'b0;
    end
    else
    begin
      ss_q   <= str_q[STR_SS] ? dig_in[SS_PIN_ALT]
                              : dig_in[SS_PIN_DEF]; // see [R14]
      ccin_q <= str_q[STR_CAPTURE_COMPARE_UNIT_TWO] ? oth_s2_q[1]
                                : oth_s2_q[0];      // see [R15]
      c1en_q <= capture_compare_unit_two_oen && !str_q[STR_CAPTURE_COMPARE_UNIT_TWO];       // see [R15] see [R16]
      b3en_q <= capture_compare_unit_two_oen && str_q[STR_CAPTURE_COMPARE_UNIT_TWO];        // see [R15] see [R16]
      c1v_q  <= !str_q[STR_CAPTURE_COMPARE_UNIT_TWO] && capture_compare_unit_two_drive;     // see [R13]
      b3v_q  <= str_q[STR_CAPTURE_COMPARE_UNIT_TWO] && capture_compare_unit_two_drive;      // see [R13]
    end
  end

  assign reg_rdata   = rdat_q;
  assign pad_out     = pout_q;
  assign pad_oe      = poe_q;
  assign ss_sense    = ss_q;
  assign capture_compare_unit_two_sense  = ccin_q;
  assign pc1_ovr_en  = c1en_q;
  assign pc1_ovr_val = c1v_q;
  assign pb3_ovr_en  = b3en_q;
  assign pb3_ovr_val = b3v_q;

  ////////////////////////////////////////////////////////////////////
  // Checks

  chk_dir_reset: assert property (@(posedge mclk)   // see [R18]
    (rst_b && !$past(rst_b)) |-> (dir_q == DIR_RST && ana_q == ANA_RST))
    else $error("direction or analog reset wrong");

  chk_pin_drive: assert property (@(posedge mclk) disable iff (!rst_b) // see [R03]
    !dir_q[1] |=> (pad_oe[1] && pad_out[1] == $past(lat_q[1])))
    else $error("pin 1 not driven from latch");

  chk_pin_float: assert property (@(posedge mclk) disable iff (!rst_b) // see [R02]
    dir_q[4] |=> !pad_oe[4])
    else $error("input pin still driven");

  chk_ana_out: assert property (@(posedge mclk) disable iff (!rst_b) // see [R10]
    (!dir_q[2] && ana_q[2]) |=> pad_oe[2])
    else $error("analog bit gated output");

  chk_level_read: assert property (@(posedge mclk) disable iff (!rst_b) // see [R04]
    (reg_rd && reg_addr == OFS_LEVEL) |=>
      reg_rdata == ($past(pa_s2_q) & ~$past(ana_q)))
    else $error("level read wrong");

  chk_ana_zero: assert property (@(posedge mclk) disable iff (!rst_b) // see [R09]
    (reg_rd && reg_addr == OFS_LEVEL && ana_q[0]) |=> !reg_rdata[0])
    else $error("analog pin read nonzero");

  chk_latch_read: assert property (@(posedge mclk) disable iff (!rst_b) // see [R07]
    (reg_rd && reg_addr == OFS_LATCH) |=> reg_rdata == $past(lat_q))
    else $error("latch read wrong");

  chk_write_same: assert property (@(posedge mclk) disable iff (!rst_b) // see [R06]
    (reg_wr && reg_addr <= OFS_LATCH) |=> lat_q == $past(reg_wdata))
    else $error("latch not written");

  chk_steer_zero: assert property (@(posedge mclk) disable iff (!rst_b) // see [R17]
    (reg_rd && reg_addr == OFS_STEER) |=> reg_rdata[7:2] == 6'h00)
    else $error("steering upper bits nonzero");

  chk_ana_mask: assert property (@(posedge mclk) disable iff (!rst_b) // see [R19]
    (reg_rd && reg_addr == OFS_ANA) |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[4])
    else $error("analog reserved bits set");

  chk_ss_route: assert property (@(posedge mclk) disable iff (!rst_b) // see [R14]
    (ss_en && str_q[1] && !dir_q[5]) |=> (!pad_oe[0] && pad_oe[5]))
    else $error("slave select on wrong pin");

  chk_ccp_route: assert property (@(posedge mclk) disable iff (!rst_b) // see [R15]
    (capture_compare_unit_two_oen && !str_q[0]) |=> (pc1_ovr_en && !pb3_ovr_en))
    else $error("capture two on wrong pin");

  chk_dir_keep: assert property (@(posedge mclk) disable iff (!rst_b) // see [R16]
    (reg_wr && reg_addr == OFS_STEER) |=> dir_q == $past(dir_q))
    else $error("steering changed direction");

  chk_sync_two: assert property (@(posedge mclk) disable iff (!rst_b) // see [R20]
    $past(rst_b, 2) |-> pa_s2_q == $past(pad_in, 2))
    else $error("pin sync depth wrong");

endmodule

// ==== tb/gps_pins.sv ====
// Board-level pin model for port A and the port B and C pins used by capture two.
// Assumes the bench sets the level that outside circuitry puts on each pin.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////
module gps_pins (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] ext_a,
  input  wire logic       pc1_ovr_en,
  input  wire logic       pc1_ovr_val,
  input  wire logic       pb3_ovr_en,
  input  wire logic       pb3_ovr_val,
  input  wire logic       ext_c1,
  input  wire logic       ext_b3,
  output logic      [7:0] pad_in,
  output logic            pc1_in,
  output logic            pb3_in
);
  // An enabled driver wins; elsewhere the board sets the level, never left floating
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_a);
  // Override of the steered capture pin wins over the board
  assign pc1_in = pc1_ovr_en ? pc1_ovr_val : ext_c1;
  assign pb3_in = pb3_ovr_en ? pb3_ovr_val : ext_b3;
endmodule

// ==== tb/gps_port_test.sv ====
// Self-checking bench for the port block with pin steering.
// Assumes gps_pkg and gps_pins are compiled first; 200 MHz clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////
module gpio_port_with_pin_steering_test;
  import gps_pkg::*;
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       ss_en = 1'b0;
  logic       capture_compare_unit_two_drive = 1'b0;
  logic       capture_compare_unit_two_oen = 1'b0;
  logic [7:0] ext_a = 8'h00;
  logic       ext_c1 = 1'b0;
  logic       ext_b3 = 1'b0;
  logic [7:0] reg_rdata, pad_in, pad_out, pad_oe;
  logic       ss_sense, capture_compare_unit_two_sense, pc1_in, pb3_in;
  logic       pc1_ovr_en, pc1_ovr_val, pb3_ovr_en, pb3_ovr_val;
  int         num_errors = 0;
  int         checks = 0;
  int         cyc = 0;

  // Clock and hang guard; the whole run needs about a hundred cycles
  always #2.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  gps_port dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .ss_en(ss_en), .ss_sense(ss_sense),
    .capture_compare_unit_two_drive(capture_compare_unit_two_drive), .capture_compare_unit_two_oen(capture_compare_unit_two_oen), .capture_compare_unit_two_sense(capture_compare_unit_two_sense),
    .pc1_in(pc1_in), .pb3_in(pb3_in), .pc1_ovr_en(pc1_ovr_en), .pc1_ovr_val(pc1_ovr_val),
    .pb3_ovr_en(pb3_ovr_en), .pb3_ovr_val(pb3_ovr_val));
  gps_pins pins (.pad_out(pad_out), .pad_oe(pad_oe), .ext_a(ext_a),
    .pc1_ovr_en(pc1_ovr_en), .pc1_ovr_val(pc1_ovr_val), .pb3_ovr_en(pb3_ovr_en),
    .pb3_ovr_val(pb3_ovr_val), .ext_c1(ext_c1), .ext_b3(ext_b3), .pad_in(pad_in),
    .pc1_in(pc1_in), .pb3_in(pb3_in));

  ////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks = checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask

  // Two synchroniser stages plus output register, with margin
  task automatic settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(OFS_DIR, 8'hff);
    rd(OFS_LATCH, 8'h00);
    rd(OFS_ANA, 8'h2f);
    rd(OFS_STEER, 8'h00);
    rd(3'h5, 8'h00);
    chk("pad_oe", 8'h00, pad_oe);
  endtask

  task automatic t_drive();
    wr(OFS_ANA, 8'h00);
    wr(OFS_LATCH, 8'ha5);
    ext_a <= 8'h5a;
    wr(OFS_DIR, 8'h00);
    settle();
    chk("pad_oe", 8'hff, pad_oe);
    chk("pad_out", 8'ha5, pad_out);
    rd(OFS_LEVEL, 8'ha5);
    rd(OFS_LATCH, 8'ha5);
    wr(OFS_DIR, 8'h0f);
    settle();
    // Low nibble floats to the board level, high nibble still driven
    rd(OFS_LEVEL, 8'haa);
    rd(OFS_LATCH, 8'ha5);
  endtask

  task automatic t_level_write();
    wr(OFS_LEVEL, 8'h3c);
    rd(OFS_LATCH, 8'h3c);
    settle();
    chk("pad_out", 8'h3c, pad_out);
  endtask

  task automatic t_analog();
    wr(OFS_DIR, 8'hff);
    wr(OFS_ANA, 8'hff);
    rd(OFS_ANA, 8'h2f);
    @(posedge mclk);
    ext_a <= 8'hff;
    settle();
    rd(OFS_LEVEL, 8'hd0);
    wr(OFS_DIR, 8'h00);
    settle();
    chk("pad_oe", 8'hff, pad_oe);
    chk("pad_out", 8'h3c, pad_out);
  endtask

  task automatic t_steer();
    wr(OFS_ANA, 8'h00);
    ext_a <= 8'h01;
    wr(OFS_STEER, 8'hff);
    rd(OFS_STEER, 8'h03);
    @(posedge mclk);
    ss_en <= 1'b1;
    capture_compare_unit_two_oen <= 1'b1;
    capture_compare_unit_two_drive <= 1'b1;
    settle();
    chk("pad_oe", 8'hfe, pad_oe);
    chk("ss_sense", 8'h01, {7'h00, ss_sense});
    chk("overrides", 8'h0c, {4'h0, pb3_ovr_en, pb3_ovr_val, pc1_ovr_en, pc1_ovr_val});
    rd(OFS_DIR, 8'h00);
    wr(OFS_STEER, 8'h00);
    settle();
    chk("pad_oe", 8'hdf, pad_oe);
    chk("ss_sense", 8'h00, {7'h00, ss_sense});
    chk("overrides", 8'h03, {4'h0, pb3_ovr_en, pb3_ovr_val, pc1_ovr_en, pc1_ovr_val});
    chk("capture_compare_unit_two_sense", 8'h01, {7'h00, capture_compare_unit_two_sense});
  endtask

  // Mid-run reset after the registers have been changed
  task automatic t_rereset();
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(OFS_DIR, 8'hff);
    rd(OFS_ANA, 8'h2f);
    rd(OFS_STEER, 8'h00);
    chk("pad_oe", 8'h00, pad_oe);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_drive();
    t_level_write();
    t_analog();
    t_steer();
    t_rereset();
    give_verdict();
  end
endmodule
